// ---- verilog/vaoc_top.v ----
// Output control of the video converter: conversion pipeline, word FIFO, pixel bus, calibration.
//
// Behaviour
// - Each sample leaves as a 16-bit unsigned word, bit 0 least significant.
// - With the double sampler in use, the word is valid 8.5 conversion clocks later.
// - Converter-only configuration gives the word 8 conversion clocks after the sample.
// - Bus enable high drives the pixel bus; low releases it to high impedance.
// - The 16 data lines and the word strobe are enabled and released together.
// - Reset low stops all activity and forces every control flip-flop to its default; pipeline and FIFO data registers are not reset.
// - During and after reset data, strobe, done and scan out are 0, SDA released.
// - Nothing converts unless the converter enable is asserted.
// - Double sampler enable picks its output; otherwise the direct video code is used.
// - Reference blocks are powered only while the reference enable is asserted.
// - A calibration mode, apart from operation, self-calibrates converter linearity.
// - Calibration enable and trigger start calibration; done output reports completion.
// - Slave address comes from four straps, most significant first, 00h to 0Fh.
// - Undriven enables default high except the double sampler enable, which defaults low; reset defaults high; clocks, calibration, scan default low.
// - Words are unsigned binary, full scale FFFFh, bottom scale 0000h.
`timescale 1ns/1ps
`include "vaoc_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module vaoc_fifo #(
  parameter W  = 16,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         clear,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;
  wire         do_push;
  wire         do_pop;

  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n || clear)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module vaoc_top (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        ENA_ADC,
  input  wire        ENA_CDS,
  input  wire        ENA_PIXEL,
  input  wire        ENA_VREF,
  input  wire        ADC_CLK,
  input  wire        SAMPLER_CLK,
  input  wire        CAL_ENA,
  input  wire        CAL_START,
  input  wire        SCAN_MODE,
  input  wire [15:0] VIDEO_CODE,
  input  wire [15:0] CDS_CODE,
  input  wire [3:0]  I2C_ADDR_STRAP,
  input  wire        SCL,
  input  wire        SDA_IN,
  output reg         SDA_OUT,
  output reg         SDA_OE,
  output reg  [15:0] PIXEL_OUT,
  output reg         PIXEL_STROBE,
  output reg         PIXEL_OE,
  output reg         CAL_DONE,
  output reg         CAL_BUSY,
  output reg         ADC_POWER_ON,
  output reg         CDS_POWER_ON,
  output reg         CDS_SELECT,
  output reg         VREF_POWER_ON,
  output reg         SCAN_OUT
);
  // The sampler clock is timed against the analog sampler only; the digital side never reads it.

  reg  [`VAOC_SYNC_W-1:0]  sync1;
  reg  [`VAOC_SYNC_W-1:0]  sync2;
  reg  [`VAOC_WORD_W-1:0]  video1;
  reg  [`VAOC_WORD_W-1:0]  video2;
  reg  [`VAOC_WORD_W-1:0]  cds1;
  reg  [`VAOC_WORD_W-1:0]  cds2;
  reg  [3:0]               strap1;
  reg  [3:0]               strap2;
  reg                      adc_prev;
  reg                      scl_prev;
  reg                      sda_prev;
  wire                     ena_adc;
  wire                     ena_cds;
  wire                     ena_pixel;
  wire                     adc_rise;
  wire                     adc_fall;
  wire                     scl_s;
  wire                     sda_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Every pin read, except reset, is synchronised; reset values mirror the pad pulls.
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      sync1    <= `VAOC_SYNC_RST;
      sync2    <= `VAOC_SYNC_RST;
      video1   <= {`VAOC_WORD_W{1'b0}};
      video2   <= {`VAOC_WORD_W{1'b0}};
      cds1     <= {`VAOC_WORD_W{1'b0}};
      cds2     <= {`VAOC_WORD_W{1'b0}};
      strap1   <= 4'h0;
      strap2   <= 4'h0;
      adc_prev <= 1'b0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      sync1    <= {SCAN_MODE, SDA_IN, SCL, CAL_START, CAL_ENA, ADC_CLK,
                   ENA_VREF, ENA_PIXEL, ENA_CDS, ENA_ADC};
      sync2    <= sync1;
      video1   <= VIDEO_CODE;
      video2   <= video1;
      cds1     <= CDS_CODE;
      cds2     <= cds1;
      strap1   <= I2C_ADDR_STRAP;
      strap2   <= strap1;
      adc_prev <= sync2[`VAOC_S_ADC_CLK];
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  assign ena_adc   = sync2[`VAOC_S_ENA_ADC];
  assign ena_cds   = sync2[`VAOC_S_ENA_CDS];
  assign ena_pixel = sync2[`VAOC_S_ENA_PIXEL];
  assign scl_s     = sync2[`VAOC_S_SCL];
  assign sda_s     = sync2[`VAOC_S_SDA];
  assign adc_rise  = sync2[`VAOC_S_ADC_CLK] & ~adc_prev;
  assign adc_fall  = ~sync2[`VAOC_S_ADC_CLK] & adc_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer, counted in conversion-clock rising edges.
  reg  [2:0]             cal_state;
  reg  [`VAOC_CAL_W-1:0] cal_count;
  reg                    start_prev;
  wire                   cal_trigger;
  wire                   run;

  assign cal_trigger = sync2[`VAOC_S_CAL_ENA] & sync2[`VAOC_S_CAL_START] & ~start_prev;
  assign run         = ena_adc & ~cal_state[1];

  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cal_state  <= `VAOC_CAL_IDLE;
      cal_count  <= {`VAOC_CAL_W{1'b0}};
      start_prev <= 1'b0;
      CAL_DONE   <= 1'b0;
      CAL_BUSY   <= 1'b0;
    end
    else
    begin
      start_prev <= sync2[`VAOC_S_CAL_START];
      case (cal_state)
        `VAOC_CAL_IDLE, `VAOC_CAL_END:
        begin
          if (cal_trigger && ena_adc)
          begin
            cal_state <= `VAOC_CAL_RUN;
            cal_count <= {`VAOC_CAL_W{1'b0}};
            CAL_DONE  <= 1'b0;
            CAL_BUSY  <= 1'b1;
          end
        end
        `VAOC_CAL_RUN:
        begin
          // Losing the converter enable abandons the run without claiming success.
          if (!ena_adc)
          begin
            cal_state <= `VAOC_CAL_IDLE;
            CAL_BUSY  <= 1'b0;
          end
          else if (adc_rise)
          begin
            if (cal_count == `VAOC_CAL_CYCLES - 1'b1)
            begin
              cal_state <= `VAOC_CAL_END;
              CAL_DONE  <= 1'b1;
              CAL_BUSY  <= 1'b0;
            end
            else
            begin
              cal_count <= cal_count + 1'b1;
            end
          end
        end
        default:
        begin
          cal_state <= `VAOC_CAL_IDLE;
          CAL_BUSY  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion pipeline. A sample enters on a rising edge and reaches the FIFO one edge
  // before it is due at the pins, so the FIFO normally holds a single word.
  reg  [`VAOC_WORD_W-1:0] pipe [0:`VAOC_PIPE_N-1];
  reg  [`VAOC_PIPE_N-1:0] pipe_v;
  wire [`VAOC_WORD_W-1:0] sample;
  wire [2:0]              tap;
  wire                    tap_v;
  wire                    push_valid;
  wire                    push_ready;
  wire                    shift;
  wire [`VAOC_WORD_W-1:0] fifo_data;
  wire                    fifo_valid;
  wire                    pop;
  wire                    out_evt;

  assign sample     = ena_cds ? cds2 : video2;
  assign tap        = ena_cds ? `VAOC_TAP_CDS : `VAOC_TAP_ADC_ONLY;
  assign tap_v      = pipe_v[tap];
  assign push_valid = adc_rise & run & tap_v;
  // A full FIFO freezes the pipeline; the samples arriving meanwhile are not taken.
  assign shift      = adc_rise & run & (push_ready | ~tap_v);

  always @(posedge CLK)
  begin
    if (!RST_N || !run)
    begin
      pipe_v <= {`VAOC_PIPE_N{1'b0}};
    end
    else if (shift)
    begin
      pipe_v <= {pipe_v[`VAOC_PIPE_N-2:0], 1'b1};
    end
  end

  always @(posedge CLK)
  begin
    if (shift)
    begin
      pipe[0] <= sample;
    end
  end

  genvar g;
  generate
    for (g = 1; g < `VAOC_PIPE_N; g = g + 1)
    begin : g_stage
      always @(posedge CLK)
      begin
        if (shift)
        begin
          pipe[g] <= pipe[g-1];
        end
      end
    end
  endgenerate

  vaoc_fifo #(
    .W  (`VAOC_WORD_W),
    .D  (`VAOC_FIFO_DEPTH),
    .AW (`VAOC_FIFO_AW)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .clear     (~run),
    .in_data   (pipe[tap]),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  // Words leave on the rising edge, or half a period later behind the double sampler.
  assign out_evt = ena_cds ? adc_fall : adc_rise;
  // A released bus stalls draining, so up to four words wait in the FIFO and more in the frozen pipeline.
  assign pop     = out_evt & ena_pixel & run & fifo_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel bus and power controls.
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      PIXEL_OUT     <= {`VAOC_WORD_W{1'b0}};
      PIXEL_STROBE  <= 1'b0;
      PIXEL_OE      <= 1'b0;
      ADC_POWER_ON  <= 1'b0;
      CDS_POWER_ON  <= 1'b0;
      CDS_SELECT    <= 1'b0;
      VREF_POWER_ON <= 1'b0;
      SCAN_OUT      <= 1'b0;
    end
    else
    begin
      PIXEL_OE      <= ena_pixel;
      ADC_POWER_ON  <= ena_adc;
      CDS_POWER_ON  <= ena_adc & ena_cds;
      CDS_SELECT    <= ena_cds;
      VREF_POWER_ON <= sync2[`VAOC_S_ENA_VREF];
      SCAN_OUT      <= 1'b0;
      if (pop)
      begin
        PIXEL_OUT    <= fifo_data;
        PIXEL_STROBE <= ~PIXEL_STROBE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-wire slave address detector: acknowledges its own strapped address only.
  reg  [3:0] i2c_state;
  reg  [7:0] i2c_shift;
  reg  [3:0] i2c_bits;
  wire       i2c_start;
  wire       i2c_stop;
  wire       scl_rise;
  wire       scl_fall;
  wire [6:0] my_addr;

  assign i2c_start = scl_s & scl_prev & sda_prev & ~sda_s;
  assign i2c_stop  = scl_s & scl_prev & ~sda_prev & sda_s;
  assign scl_rise  = scl_s & ~scl_prev;
  assign scl_fall  = ~scl_s & scl_prev;
  assign my_addr   = {`VAOC_I2C_ADDR_HI, strap2};

  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      i2c_state <= `VAOC_I2C_IDLE;
      i2c_shift <= 8'h00;
      i2c_bits  <= 4'h0;
      SDA_OUT   <= 1'b0;
      SDA_OE    <= 1'b0;
    end
    else if (i2c_start)
    begin
      i2c_state <= `VAOC_I2C_ADDR;
      i2c_bits  <= 4'h0;
      SDA_OE    <= 1'b0;
    end
    else if (i2c_stop)
    begin
      i2c_state <= `VAOC_I2C_IDLE;
      SDA_OE    <= 1'b0;
    end
    else
    begin
      case (i2c_state)
        `VAOC_I2C_IDLE:
        begin
          SDA_OE <= 1'b0;
        end
        `VAOC_I2C_ADDR:
        begin
          if (scl_rise)
          begin
            i2c_shift <= {i2c_shift[6:0], sda_s};
            i2c_bits  <= i2c_bits + 1'b1;
          end
          else if (scl_fall && i2c_bits == `VAOC_I2C_BITS)
          begin
            if (i2c_shift[7:1] == my_addr)
            begin
              i2c_state <= `VAOC_I2C_ACK;
              SDA_OE    <= 1'b1;
            end
            else
            begin
              i2c_state <= `VAOC_I2C_WAIT;
            end
          end
        end
        `VAOC_I2C_ACK:
        begin
          if (scl_fall)
          begin
            i2c_state <= `VAOC_I2C_WAIT;
            SDA_OE    <= 1'b0;
          end
        end
        `VAOC_I2C_WAIT:
        begin
          SDA_OE <= 1'b0;
        end
        default:
        begin
          i2c_state <= `VAOC_I2C_IDLE;
          SDA_OE    <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- verilog/vaoc_defines.vh ----
// Constants for the video converter output control block.
`ifndef VAOC_DEFINES_VH
`define VAOC_DEFINES_VH

// Pixel word and pipeline geometry.
`define VAOC_WORD_W        16
`define VAOC_PIPE_N        8
`define VAOC_TAP_ADC_ONLY  3'h6
`define VAOC_TAP_CDS       3'h7
`define VAOC_FIFO_DEPTH    4
`define VAOC_FIFO_AW       2

// Positions in the synchronised control bundle.
`define VAOC_SYNC_W        10
`define VAOC_S_ENA_ADC     0
`define VAOC_S_ENA_CDS     1
`define VAOC_S_ENA_PIXEL   2
`define VAOC_S_ENA_VREF    3
`define VAOC_S_ADC_CLK     4
`define VAOC_S_CAL_ENA     5
`define VAOC_S_CAL_START   6
`define VAOC_S_SCL         7
`define VAOC_S_SDA         8
`define VAOC_S_SCAN_MODE   9

// Reset level of each bundle bit equals the pad pull: enables other than ENA_CDS pulled up, the rest down,
// SCL and SDA idle high on the bus.
`define VAOC_SYNC_RST      10'h18D

// Calibration length in conversion-clock rising edges.
`define VAOC_CAL_W         12
`define VAOC_CAL_CYCLES    12'h400

// Calibration states, one-hot.
`define VAOC_CAL_IDLE      3'h1
`define VAOC_CAL_RUN       3'h2
`define VAOC_CAL_END       3'h4

// Two-wire address detector states, one-hot, and address layout.
`define VAOC_I2C_IDLE      4'h1
`define VAOC_I2C_ADDR      4'h2
`define VAOC_I2C_ACK       4'h4
`define VAOC_I2C_WAIT      4'h8
`define VAOC_I2C_ADDR_HI   3'h0
`define VAOC_I2C_BITS      4'h8

`endif

// ---- tb/vaoc_top_sva.sv ----
// Port-level checker for the video converter output control block.
`timescale 1ns/1ps
module vaoc_top_sva (
  input wire        CLK,
  input wire        RST_N,
  input wire        ENA_ADC,
  input wire        ENA_CDS,
  input wire        ENA_PIXEL,
  input wire        ENA_VREF,
  input wire        SCL,
  input wire        SDA_OUT,
  input wire        SDA_OE,
  input wire [15:0] PIXEL_OUT,
  input wire        PIXEL_STROBE,
  input wire        PIXEL_OE,
  input wire        CAL_DONE,
  input wire        CAL_BUSY,
  input wire        ADC_POWER_ON,
  input wire        CDS_POWER_ON,
  input wire        VREF_POWER_ON,
  input wire        SCAN_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // Reset is the antecedent here, so this one must not be disabled by it.
  a_reset_zero: assert property (disable iff (1'b0) !RST_N |=> PIXEL_OUT == 16'h0000
    && !PIXEL_STROBE && !CAL_DONE && !SCAN_OUT && !SDA_OE) else $error("outputs not cleared");
  a_tie_low: assert property (!SCAN_OUT && !SDA_OUT) else $error("tied output high");
  a_oe_follow: assert property ($stable(ENA_PIXEL)[*5] |-> PIXEL_OE == ENA_PIXEL)
    else $error("bus enable wrong");
  a_bus_hold: assert property ((!ENA_PIXEL)[*5] |-> $stable(PIXEL_STROBE) && $stable(PIXEL_OUT))
    else $error("bus moved while released");
  a_adc_idle: assert property ((!ENA_ADC)[*5] |=> $stable(PIXEL_STROBE) && !ADC_POWER_ON)
    else $error("activity without converter enable");
  a_vref_mirror: assert property ($stable(ENA_VREF)[*5] |-> VREF_POWER_ON == ENA_VREF)
    else $error("reference power wrong");
  a_cds_power: assert property ($stable({ENA_ADC, ENA_CDS})[*5]
    |-> CDS_POWER_ON == (ENA_ADC && ENA_CDS)) else $error("sampler power wrong");
  a_cal_quiet: assert property (CAL_BUSY[*3] |-> $stable(PIXEL_STROBE) && !CAL_DONE)
    else $error("words during calibration");
  a_done_end: assert property ($rose(CAL_DONE) |-> $fell(CAL_BUSY))
    else $error("done without busy end");
  a_ack_low: assert property ($rose(SDA_OE) |-> !SCL) else $error("ack not in clock low");
  a_word_strobe: assert property ($changed(PIXEL_OUT) |-> $changed(PIXEL_STROBE))
    else $error("word without strobe");
endmodule

// ---- tb/vaoc_ctrl_model.sv ----
// Camera controller model: conversion and sampler clocks, strobe edge counter.
`timescale 1ns/1ps
module vaoc_ctrl_model (
  input  wire    run,
  input  wire    strobe,
  output reg     adc_clk,
  output reg     smp_clk,
  output integer edges
);
  initial
  begin
    adc_clk = 1'b0;
    smp_clk = 1'b0;
    edges   = 0;
  end
  // One sample per pixel, 50 percent duty, sampler falls 25 ns after the rise.
  // The clock stands low while not running.
  always
  begin
    if (run)
    begin
      adc_clk = 1'b1;
      #25 smp_clk = 1'b0;
      #75 adc_clk = 1'b0;
      #50 smp_clk = 1'b1;
      #50;
    end
    else
      #25;
  end
  // The receiver captures on both strobe edges.
  always @(strobe)
    edges = edges + 1;
endmodule

// ---- tb/tb_vaoc_top.sv ----
// Self-checking testbench for the video converter output control block.
`timescale 1ns/1ps
module tb_vaoc_top;
  reg         clk = 0, rst_n = 0, run = 0, ena_adc = 1, ena_cds = 0, ena_pixel = 1;
  reg         ena_vref = 1, cal_ena = 0, cal_start = 0, scl = 1, sda_drv = 1;
  reg  [15:0] video = 16'h1234, cds = 16'h1234;
  reg  [3:0]  strap = 4'hA;
  wire        adc_clk, smp_clk, sda_out, sda_oe, strobe, pix_oe, cal_done, cal_busy;
  wire        adc_on, cds_on, cds_sel, vref_on, scan_out;
  wire [15:0] pix;
  wire        sda = sda_drv & ~sda_oe;
  integer     edges, e0, n, i, cyc = 0, mismatches = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  vaoc_ctrl_model ctrl (.run(run), .strobe(strobe), .adc_clk(adc_clk), .smp_clk(smp_clk),
    .edges(edges));
  vaoc_top uut (.CLK(clk), .RST_N(rst_n), .ENA_ADC(ena_adc), .ENA_CDS(ena_cds),
    .ENA_PIXEL(ena_pixel), .ENA_VREF(ena_vref), .ADC_CLK(adc_clk), .SAMPLER_CLK(smp_clk),
    .CAL_ENA(cal_ena), .CAL_START(cal_start), .SCAN_MODE(1'b0), .VIDEO_CODE(video),
    .CDS_CODE(cds), .I2C_ADDR_STRAP(strap), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .PIXEL_OUT(pix), .PIXEL_STROBE(strobe), .PIXEL_OE(pix_oe),
    .CAL_DONE(cal_done), .CAL_BUSY(cal_busy), .ADC_POWER_ON(adc_on), .CDS_POWER_ON(cds_on),
    .CDS_SELECT(cds_sel), .VREF_POWER_ON(vref_on), .SCAN_OUT(scan_out));
  ////////////////////////////////////////
  task check(input [31:0] got, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task tick(input integer k);
    repeat (k) @(negedge clk);
  endtask
  task summarize;
  begin
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  ////////////////////////////////////////
  task reset_check;
  begin
    rst_n = 0;
    tick(20);
    check({pix, strobe, cal_done, scan_out, sda_oe, sda_out}, 0);
    rst_n = 1;
    tick(1);
    check({pix, strobe, cal_done, scan_out, sda_oe, sda_out}, 0);
    tick(5);
  end
  endtask
  // The unselected source carries the inverse, so a wrong selection never matches.
  task t_latency(input c, input [15:0] v, input integer lo);
  begin
    ena_cds = c;
    tick(96);
    @(negedge adc_clk);
    @(negedge clk);
    if (c) {cds, video} = {v, ~v};
    else {video, cds} = {v, ~v};
    @(posedge adc_clk);
    n = 0;
    while (pix !== v && n < 200)
    begin
      @(negedge clk);
      n = n + 1;
    end
    check(n >= lo && n <= lo + 6, 1);
    check(pix, v);
    check(cds_sel, c);
  end
  endtask
  task t_strobe;
  begin
    @(posedge adc_clk);
    e0 = edges;
    repeat (10) @(posedge adc_clk);
    check(edges - e0, 10);
  end
  endtask
  task t_pixel_off;
  begin
    ena_pixel = 0;
    tick(5);
    check(pix_oe, 0);
    e0 = edges;
    tick(96);
    check(edges - e0, 0);
    ena_pixel = 1;
    tick(4);
    check(pix_oe, 1);
    e0 = edges;
    tick(8);
    check(edges - e0 > 0, 1);
    tick(96);
  end
  endtask
  task t_disable;
  begin
    {ena_adc, ena_vref} = 2'b00;
    tick(5);
    check({adc_on, cds_on, vref_on}, 0);
    e0 = edges;
    tick(100);
    check(edges - e0, 0);
    {ena_adc, ena_vref} = 2'b11;
    tick(5);
    check({adc_on, vref_on}, 2'b11);
    tick(96);
  end
  endtask
  task t_i2c(input [7:0] b, input exp);
  begin
    scl = 1;
    sda_drv = 1;
    tick(20);
    sda_drv = 0;
    tick(20);
    scl = 0;
    for (i = 7; i >= 0; i = i - 1)
    begin
      tick(10);
      sda_drv = b[i];
      tick(10);
      scl = 1;
      tick(20);
      scl = 0;
    end
    tick(10);
    sda_drv = 1;
    tick(5);
    check(sda_oe, exp);
    scl = 1;
    tick(20);
    scl = 0;
    tick(10);
    check(sda_oe, 0);
    sda_drv = 0;
    tick(10);
    scl = 1;
    tick(10);
    sda_drv = 1;
    tick(20);
  end
  endtask
  task t_calib;
  begin
    cal_start = 1;
    tick(6);
    check(cal_busy, 0);
    cal_start = 0;
    cal_ena = 1;
    @(posedge adc_clk);
    @(negedge clk);
    cal_start = 1;
    tick(6);
    check({cal_busy, cal_done}, 2'b10);
    e0 = edges;
    n = 6;
    while (cal_done !== 1'b1 && n < 9000)
    begin
      @(negedge clk);
      n = n + 1;
    end
    check(n >= 8190 && n <= 8199, 1);
    check(edges - e0, 0);
    cal_start = 0;
    tick(4);
    cal_start = 1;
    tick(6);
    check({cal_busy, cal_done}, 2'b10);
    ena_adc = 0;
    tick(6);
    check({cal_busy, cal_done}, 0);
    {cal_start, cal_ena, ena_adc} = 3'b001;
    tick(100);
  end
  endtask
  ////////////////////////////////////////
  initial
  begin
    reset_check;
    run = 1;
    // The model's references settle at once, so this wait stands for the power-up allowance.
    tick(96);
    t_latency(0, 16'h8001, 64);
    t_latency(0, 16'hFFFF, 64);
    t_latency(1, 16'h00FF, 68);
    t_latency(1, 16'h7FFE, 68);
    t_strobe;
    t_pixel_off;
    t_disable;
    // Conversion pauses so that the address traffic never disturbs useful pixels.
    run = 0;
    tick(8);
    t_i2c(8'h14, 1);
    t_i2c(8'h16, 0);
    strap = 4'hF;
    tick(5);
    t_i2c(8'h1F, 1);
    run = 1;
    t_calib;
    reset_check;
    summarize;
  end
endmodule
bind vaoc_top vaoc_top_sva chk (.CLK(CLK), .RST_N(RST_N), .ENA_ADC(ENA_ADC), .ENA_CDS(ENA_CDS),
  .ENA_PIXEL(ENA_PIXEL), .ENA_VREF(ENA_VREF), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .PIXEL_OUT(PIXEL_OUT), .PIXEL_STROBE(PIXEL_STROBE), .PIXEL_OE(PIXEL_OE), .CAL_DONE(CAL_DONE),
  .CAL_BUSY(CAL_BUSY), .ADC_POWER_ON(ADC_POWER_ON), .CDS_POWER_ON(CDS_POWER_ON),
  .VREF_POWER_ON(VREF_POWER_ON), .SCAN_OUT(SCAN_OUT));
